// File: core/cdr_pkg.sv
package cdr_pkg;

    localparam int CDR_AW = 8;
    localparam int CDR_DW = 32;

    // register byte addresses on the APB window
    localparam logic [7:0] CDR_REG_PSW = 8'h80;
    localparam logic [7:0] CDR_REG_SP = 8'h84;
    localparam logic [7:0] CDR_REG_DPL = 8'h88;
    localparam logic [7:0] CDR_REG_DPH = 8'h8C;
    localparam logic [7:0] CDR_REG_ACC = 8'h90;
    localparam logic [7:0] CDR_REG_B = 8'h94;
    localparam logic [7:0] CDR_REG_DPSEL = 8'h98;
    localparam logic [7:0] CDR_REG_PCL = 8'h9C;
    localparam logic [7:0] CDR_REG_PCH = 8'hA0;

    // status word fields
    localparam int PSW_CY = 7;
    localparam int PSW_AC = 6;
    localparam int PSW_F0 = 5;
    localparam int PSW_RS1 = 4;
    localparam int PSW_RS0 = 3;
    localparam int PSW_OV = 2;
    localparam int PSW_F1 = 1;
    localparam int PSW_P = 0;
    localparam logic [7:0] PSW_WR_MASK = 8'hFE;

    // reset values
    localparam logic [7:0] RST_PSW = 8'h00;
    localparam logic [7:0] RST_SP = 8'h07;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_W1 = 5'b00010,
        ST_W2 = 5'b00100,
        ST_P1 = 5'b01000,
        ST_P2 = 5'b10000
    } cdr_state_t;

    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADDC = 6'h02, OP_SUBB = 6'h03,
        OP_INC = 6'h04, OP_DEC = 6'h05, OP_MUL = 6'h06, OP_DIV = 6'h07,
        OP_DA = 6'h08, OP_CMP = 6'h09, OP_ANL = 6'h0A, OP_ORL = 6'h0B,
        OP_XRL = 6'h0C, OP_CPL = 6'h0D, OP_CLR = 6'h0E, OP_RR = 6'h0F,
        OP_RL = 6'h10, OP_RRC = 6'h11, OP_RLC = 6'h12, OP_SWAP = 6'h13,
        OP_SETB = 6'h14, OP_CLRB = 6'h15, OP_CPLB = 6'h16, OP_JB = 6'h17,
        OP_JNB = 6'h18, OP_JBC = 6'h19, OP_MOVCB = 6'h1A, OP_MOVBC = 6'h1B,
        OP_ANLC = 6'h1C, OP_ANLCN = 6'h1D, OP_ORLC = 6'h1E, OP_ORLCN = 6'h1F,
        OP_PUSH = 6'h20, OP_POP = 6'h21, OP_CALL = 6'h22, OP_RET = 6'h23,
        OP_DPLD = 6'h24, OP_DPINC = 6'h25, OP_JMP = 6'h26, OP_JMPI = 6'h27
    } cdr_op_t;

endpackage

// File: core/cdr_core.sv
// Contract
// - machine cycle is two clocks when memory needs no wait state
// - slow program memory access adds exactly one machine cycle wait
// - alu takes 8-bit operands, gives 8-bit result chosen by decoder
// - add, subtract, multiply, divide, inc, dec, decimal adjust, compare
// - and, or, xor, complement, rotate right/left, nibble swap
// - set, clear, complement bits; branch on set/clear/set-and-clear; carry moves
// - carry and/or with a bit or its inverse, result into carry
// - 16-bit program counter holds next address; branches redirect it
// - core registers sit in the 80h to FFh direct space
// - stack pre-increments on write, post-decrements on read
// - reset loads stack pointer with 07h
// - calls push pc, returns pop it, push/pop move data bytes
// - software reads and writes stack pointer while the core is idle
// - data pointer is high and low byte forming a 16-bit address
// - data pointer supports load immediate and increment with carry
// - main operand register supplies one operand for most alu ops
// - second operand register feeds multiply/divide, else scratch
// - status word resets to 00 with documented field layout
// - parity bit is read-only, set when accumulator has odd ones
// - bank select bits pick register bank at 00h, 08h, 10h, 18h
// - half carry updated by add and subtract ops (not decimal adjust) and software writable
// - carry and overflow updated by arithmetic, software writable
// - select bit picks first or second data pointer
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
module cdr_core
    import cdr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CDR_AW-1:0] paddr,
    input wire logic [CDR_DW-1:0] pwdata,
    output logic [CDR_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    output logic op_ready,
    input wire logic [5:0] op_code,
    input wire logic [7:0] op_src,
    input wire logic [15:0] op_imm,
    input wire logic [1:0] op_len,
    input wire logic op_bit,
    input wire logic op_bit_cy,
    input wire logic op_slow,
    output logic op_done,
    output logic branch_taken,
    output logic [7:0] res_data,
    output logic res_we,
    output logic bit_data,
    output logic bit_we,
    output logic [7:0] stk_addr,
    output logic [7:0] stk_wdata,
    output logic stk_we,
    input wire logic [7:0] stk_rdata,
    output logic [15:0] program_counter,
    output logic [15:0] data_pointer,
    output logic [1:0] bank_select
);

    cdr_state_t st_q, st_d;
    cdr_op_t op_q, op_d;
    logic [7:0] src_q, src_d;
    logic [15:0] imm_q, imm_d;
    logic [1:0] len_q, len_d;
    logic bit_q, bit_d, bitcy_q, bitcy_d, cnt_q, cnt_d;
    logic [7:0] acc_q, acc_d, b_q, b_d, psw_q, psw_d, sp_q, sp_d;
    logic [15:0] pc_q, pc_d, act_dp_q, act_dp_d, alt_dp_q, alt_dp_d;
    logic dpsel_q, dpsel_d;
    logic done_q, done_d, taken_q, taken_d, rwe_q, rwe_d, bwe_q, bwe_d, bout_q, bout_d;
    logic [7:0] res_q, res_d, saddr_q, saddr_d, swd_q, swd_d;
    logic swe_q, swe_d, rdy_q, rdy_d;
    logic [31:0] prd_q, prd_d;
    logic prdy_q, prdy_d, perr_q, perr_d;

    // alu outputs
    logic [7:0] a_res, b_res;
    logic cy_n, ac_n, ov_n, alu_taken, bit_n, bit_wr, cin;
    logic [8:0] sum9, dif9, da9;
    logic [4:0] lo5, lod5;
    logic [15:0] prod, pc_ret;
    logic push_op, is2, apb_hit, apb_err;
    logic [7:0] apb_val;

    assign prdata = prd_q;
    assign pready = prdy_q;
    assign pslverr = perr_q;
    assign op_ready = rdy_q;
    assign op_done = done_q;
    assign branch_taken = taken_q;
    assign res_data = res_q;
    assign res_we = rwe_q;
    assign bit_data = bout_q;
    assign bit_we = bwe_q;
    assign stk_addr = saddr_q;
    assign stk_wdata = swd_q;
    assign stk_we = swe_q;
    assign program_counter = pc_q;
    assign data_pointer = act_dp_q;
    assign bank_select = psw_q[PSW_RS1:PSW_RS0];

    always_comb
    begin
        a_res = acc_q;
        b_res = b_q;
        cy_n = psw_q[PSW_CY];
        ac_n = psw_q[PSW_AC];
        ov_n = psw_q[PSW_OV];
        alu_taken = 1'b0;
        bit_n = bit_q;
        bit_wr = 1'b0;
        cin = (op_q == OP_ADDC || op_q == OP_SUBB) && psw_q[PSW_CY];
        sum9 = {1'b0, acc_q} + {1'b0, src_q} + {8'h00, cin};
        dif9 = {1'b0, acc_q} - {1'b0, src_q} - {8'h00, cin};
        lo5 = {1'b0, acc_q[3:0]} + {1'b0, src_q[3:0]} + {4'h0, cin};
        lod5 = {1'b0, acc_q[3:0]} - {1'b0, src_q[3:0]} - {4'h0, cin};
        prod = acc_q * b_q;
        da9 = {1'b0, acc_q};
        if (acc_q[3:0] > 4'h9 || psw_q[PSW_AC])
        begin
            da9 = da9 + 9'h006;
        end
        if (da9[7:4] > 4'h9 || da9[8] || psw_q[PSW_CY])
        begin
            da9 = da9 + 9'h060;
        end
        unique case (op_q)
            OP_ADD, OP_ADDC:
            begin
                a_res = sum9[7:0];
                cy_n = sum9[8];
                ac_n = lo5[4];
                ov_n = (acc_q[7] == src_q[7]) && (sum9[7] != acc_q[7]);
            end
            OP_SUBB:
            begin
                a_res = dif9[7:0];
                cy_n = dif9[8];
                ac_n = lod5[4];
                ov_n = (acc_q[7] != src_q[7]) && (dif9[7] != acc_q[7]);
            end
            OP_INC: a_res = acc_q + 8'h01;
            OP_DEC: a_res = acc_q - 8'h01;
            OP_MUL:
            begin
                a_res = prod[7:0];
                b_res = prod[15:8];
                cy_n = 1'b0;
                ov_n = |prod[15:8];
            end
            OP_DIV:
            begin
                cy_n = 1'b0;
                // divide by zero leaves both operands and flags overflow
                ov_n = (b_q == 8'h00);
                if (b_q != 8'h00)
                begin
                    a_res = acc_q / b_q;
                    b_res = acc_q % b_q;
                end
            end
            OP_DA:
            begin
                a_res = da9[7:0];
                cy_n = psw_q[PSW_CY] | da9[8];
            end
            OP_CMP:
            begin
                cy_n = acc_q < src_q;
                alu_taken = acc_q != src_q;
            end
            OP_ANL: a_res = acc_q & src_q;
            OP_ORL: a_res = acc_q | src_q;
            OP_XRL: a_res = acc_q ^ src_q;
            OP_CPL: a_res = ~acc_q;
            OP_CLR: a_res = 8'h00;
            OP_RR: a_res = {acc_q[0], acc_q[7:1]};
            OP_RL: a_res = {acc_q[6:0], acc_q[7]};
            OP_RRC:
            begin
                a_res = {psw_q[PSW_CY], acc_q[7:1]};
                cy_n = acc_q[0];
            end
            OP_RLC:
            begin
                a_res = {acc_q[6:0], psw_q[PSW_CY]};
                cy_n = acc_q[7];
            end
            OP_SWAP: a_res = {acc_q[3:0], acc_q[7:4]};
            OP_SETB, OP_CLRB, OP_CPLB:
            begin
                bit_n = (op_q == OP_SETB) || (op_q == OP_CPLB && !bit_q);
                if (bitcy_q)
                begin
                    cy_n = (op_q == OP_SETB) || (op_q == OP_CPLB && !psw_q[PSW_CY]);
                end
                else
                begin
                    bit_wr = 1'b1;
                end
            end
            OP_JB: alu_taken = bit_q;
            OP_JNB: alu_taken = !bit_q;
            OP_JBC:
            begin
                alu_taken = bit_q;
                bit_n = 1'b0;
                bit_wr = bit_q;
            end
            OP_MOVCB: cy_n = bit_q;
            OP_MOVBC:
            begin
                bit_n = psw_q[PSW_CY];
                bit_wr = 1'b1;
            end
            OP_ANLC: cy_n = psw_q[PSW_CY] & bit_q;
            OP_ANLCN: cy_n = psw_q[PSW_CY] & !bit_q;
            OP_ORLC: cy_n = psw_q[PSW_CY] | bit_q;
            OP_ORLCN: cy_n = psw_q[PSW_CY] | !bit_q;
            OP_JMP: alu_taken = 1'b1;
            default:
            begin
                alu_taken = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        st_d = st_q;
        op_d = op_q;
        src_d = src_q;
        imm_d = imm_q;
        len_d = len_q;
        bit_d = bit_q;
        bitcy_d = bitcy_q;
        cnt_d = cnt_q;
        acc_d = acc_q;
        b_d = b_q;
        psw_d = psw_q;
        sp_d = sp_q;
        pc_d = pc_q;
        act_dp_d = act_dp_q;
        alt_dp_d = alt_dp_q;
        dpsel_d = dpsel_q;
        done_d = 1'b0;
        taken_d = 1'b0;
        rwe_d = 1'b0;
        bwe_d = 1'b0;
        bout_d = bout_q;
        res_d = res_q;
        saddr_d = saddr_q;
        swd_d = swd_q;
        swe_d = 1'b0;
        prd_d = prd_q;
        prdy_d = 1'b0;
        perr_d = 1'b0;
        pc_ret = pc_q + {14'h0000, len_q};
        push_op = (op_q == OP_PUSH) || (op_q == OP_CALL);
        is2 = (op_q == OP_CALL) || (op_q == OP_RET);
        unique case (st_q)
            ST_IDLE:
            begin
                if (op_valid && rdy_q)
                begin
                    op_d = cdr_op_t'(op_code);
                    src_d = op_src;
                    imm_d = op_imm;
                    len_d = op_len;
                    bit_d = op_bit;
                    bitcy_d = op_bit_cy;
                    cnt_d = 1'b0;
                    st_d = op_slow ? ST_W1 : ST_P1;
                end
            end
            ST_W1: st_d = ST_W2;
            ST_W2: st_d = ST_P1;
            ST_P1:
            begin
                // pointer set up one clock early so memory sees a stable address
                saddr_d = push_op ? sp_q + 8'h01 : sp_q;
                swe_d = push_op;
                if (op_q == OP_CALL)
                begin
                    swd_d = cnt_q ? pc_ret[15:8] : pc_ret[7:0];
                end
                else
                begin
                    swd_d = src_q;
                end
                st_d = ST_P2;
            end
            ST_P2:
            begin
                if (push_op)
                begin
                    sp_d = sp_q + 8'h01;
                end
                else if (op_q == OP_POP || op_q == OP_RET)
                begin
                    sp_d = sp_q - 8'h01;
                end
                if (is2 && !cnt_q)
                begin
                    cnt_d = 1'b1;
                    st_d = ST_P1;
                    if (op_q == OP_RET)
                    begin
                        pc_d[15:8] = stk_rdata;
                    end
                end
                else
                begin
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                    acc_d = a_res;
                    b_d = b_res;
                    psw_d[PSW_CY] = cy_n;
                    psw_d[PSW_AC] = ac_n;
                    psw_d[PSW_OV] = ov_n;
                    bout_d = bit_n;
                    bwe_d = bit_wr;
                    taken_d = alu_taken || op_q == OP_JMPI;
                    pc_d = alu_taken ? imm_q : pc_ret;
                    unique case (op_q)
                        OP_POP:
                        begin
                            res_d = stk_rdata;
                            rwe_d = 1'b1;
                        end
                        OP_CALL:
                        begin
                            pc_d = imm_q;
                            taken_d = 1'b1;
                        end
                        OP_RET:
                        begin
                            pc_d = {pc_q[15:8], stk_rdata};
                            taken_d = 1'b1;
                        end
                        OP_JMPI: pc_d = act_dp_q + {8'h00, acc_q};
                        OP_DPLD: act_dp_d = imm_q;
                        OP_DPINC: act_dp_d = act_dp_q + 16'h0001;
                        default:
                        begin
                            res_d = res_q;
                        end
                    endcase
                end
            end
        endcase
        rdy_d = (st_d == ST_IDLE);
        // apb answers only while the core is idle and no op starts, so the
        // two sides never write a register in the same cycle; a decoder
        // that never drops op_valid starves the bus
        apb_hit = 1'b1;
        apb_val = 8'h00;
        unique case (paddr)
            CDR_REG_PSW: apb_val = {psw_q[7:1], ^acc_q};
            CDR_REG_SP: apb_val = sp_q;
            CDR_REG_DPL: apb_val = act_dp_q[7:0];
            CDR_REG_DPH: apb_val = act_dp_q[15:8];
            CDR_REG_ACC: apb_val = acc_q;
            CDR_REG_B: apb_val = b_q;
            CDR_REG_DPSEL: apb_val = {7'h00, dpsel_q};
            CDR_REG_PCL: apb_val = pc_q[7:0];
            CDR_REG_PCH: apb_val = pc_q[15:8];
            default: apb_hit = 1'b0;
        endcase
        apb_err = !apb_hit || (pwrite && (paddr == CDR_REG_PCL || paddr == CDR_REG_PCH));
        if (psel && penable && !prdy_q && st_q == ST_IDLE && !(op_valid && rdy_q))
        begin
            prdy_d = 1'b1;
            perr_d = apb_err;
            prd_d = {24'h000000, apb_val};
        end
        if (psel && penable && prdy_q && pwrite && !perr_q)
        begin
            unique case (paddr)
                // parity is not stored; user flags and bank bits are plain storage
                CDR_REG_PSW: psw_d = pwdata[7:0] & PSW_WR_MASK;
                CDR_REG_SP: sp_d = pwdata[7:0];
                CDR_REG_DPL: act_dp_d[7:0] = pwdata[7:0];
                CDR_REG_DPH: act_dp_d[15:8] = pwdata[7:0];
                CDR_REG_ACC: acc_d = pwdata[7:0];
                CDR_REG_B: b_d = pwdata[7:0];
                CDR_REG_DPSEL:
                begin
                    dpsel_d = pwdata[0];
                    if (pwdata[0] != dpsel_q)
                    begin
                        act_dp_d = alt_dp_q;
                        alt_dp_d = act_dp_q;
                    end
                end
                default:
                begin
                    dpsel_d = dpsel_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= ST_IDLE;
            op_q <= OP_NOP;
            src_q <= RST_BYTE;
            imm_q <= RST_WORD;
            len_q <= 2'h0;
            bit_q <= 1'b0;
            bitcy_q <= 1'b0;
            cnt_q <= 1'b0;
            acc_q <= RST_BYTE;
            b_q <= RST_BYTE;
            psw_q <= RST_PSW;
            sp_q <= RST_SP;
            pc_q <= RST_WORD;
            act_dp_q <= RST_WORD;
            alt_dp_q <= RST_WORD;
            dpsel_q <= 1'b0;
            done_q <= 1'b0;
            taken_q <= 1'b0;
            rwe_q <= 1'b0;
            bwe_q <= 1'b0;
            bout_q <= 1'b0;
            res_q <= RST_BYTE;
            saddr_q <= RST_BYTE;
            swd_q <= RST_BYTE;
            swe_q <= 1'b0;
            rdy_q <= 1'b0;
            prd_q <= 32'h00000000;
            prdy_q <= 1'b0;
            perr_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            op_q <= op_d;
            src_q <= src_d;
            imm_q <= imm_d;
            len_q <= len_d;
            bit_q <= bit_d;
            bitcy_q <= bitcy_d;
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            b_q <= b_d;
            psw_q <= psw_d;
            sp_q <= sp_d;
            pc_q <= pc_d;
            act_dp_q <= act_dp_d;
            alt_dp_q <= alt_dp_d;
            dpsel_q <= dpsel_d;
            done_q <= done_d;
            taken_q <= taken_d;
            rwe_q <= rwe_d;
            bwe_q <= bwe_d;
            bout_q <= bout_d;
            res_q <= res_d;
            saddr_q <= saddr_d;
            swd_q <= swd_d;
            swe_q <= swe_d;
            rdy_q <= rdy_d;
            prd_q <= prd_d;
            prdy_q <= prdy_d;
            perr_q <= perr_d;
        end
    end

endmodule

// File: dv/cdr_core_properties.sv
`timescale 1ns/1ns
module cdr_core_properties
    import cdr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire logic [5:0] op_code,
    input wire logic [7:0] op_src,
    input wire logic [15:0] op_imm,
    input wire logic op_slow,
    input wire logic op_done,
    input wire logic branch_taken,
    input wire logic res_we,
    input wire logic [7:0] stk_wdata,
    input wire logic stk_we,
    input wire logic [15:0] program_counter,
    input wire logic [15:0] data_pointer
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic take;
    logic long_op;
    assign take = op_valid && op_ready;
    assign long_op = op_code == OP_CALL || op_code == OP_RET;
    fast_cycle_a: assert property (take && !op_slow && !long_op |-> ##1 !op_done [*2] ##1 op_done)
        else $error("fast op did not finish in three clocks");
    slow_wait_a: assert property (take && op_slow && !long_op |-> ##1 !op_done [*4] ##1 op_done)
        else $error("slow op did not finish in five clocks");
    call_cycles_a: assert property (take && !op_slow && long_op |-> ##5 op_done)
        else $error("call or return did not finish in five clocks");
    push_write_a: assert property (take && !op_slow && op_code == OP_PUSH
        |-> ##2 stk_we && stk_wdata == $past(op_src, 2))
        else $error("push did not write its byte");
    ptr_load_a: assert property (take && !op_slow && op_code == OP_DPLD
        |-> ##3 data_pointer == $past(op_imm, 3))
        else $error("pointer load value wrong");
    jump_target_a: assert property (take && !op_slow && op_code == OP_JMP
        |-> ##3 branch_taken && program_counter == $past(op_imm, 3))
        else $error("jump did not redirect the counter");
    pulse_done_a: assert property (branch_taken || res_we |-> op_done)
        else $error("branch or pop strobe without completion");
    unmapped_err_a: assert property (pready && psel && paddr > 8'hA0 |-> pslverr)
        else $error("unmapped access not refused");
    pc_locked_a: assert property (pready && pwrite && paddr inside {8'h9C, 8'hA0} |-> pslverr)
        else $error("counter write not refused");
    bus_answer_a: assert property (psel && penable && !pready |-> ##[1:30] pready)
        else $error("bus access never answered");
endmodule

// File: dv/cdr_stack_ram.sv
`timescale 1ns/1ns
module cdr_stack_ram
(
    input wire logic sys_clk,
    input wire logic [7:0] stk_addr,
    input wire logic [7:0] stk_wdata,
    input wire logic stk_we,
    output logic [7:0] stk_rdata
);
    logic [7:0] mem [256];
    // read is asynchronous: the core samples at the end of the same phase
    assign stk_rdata = mem[stk_addr];
    always @(posedge sys_clk)
    begin
        if (stk_we)
            mem[stk_addr] <= stk_wdata;
    end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import cdr_pkg::*;
;
    typedef struct {cdr_op_t op; logic [7:0] a; logic [7:0] s; logic [7:0] ea; logic ecy;} cdr_row_t;
    localparam logic [7:0] A_STAT = 8'h80;
    localparam logic [7:0] A_STK = 8'h84;
    localparam logic [7:0] A_ACC = 8'h90;
    localparam logic [7:0] A_OPB = 8'h94;
    localparam logic [7:0] A_SEL = 8'h98;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, stk_addr, stk_wdata, stk_rdata, res_data, rdat;
    logic [31:0] pwdata, prdata;
    logic op_valid, op_ready, op_bit, op_bit_cy, op_slow, op_done, branch_taken;
    logic [5:0] op_code;
    logic [7:0] op_src;
    logic [15:0] op_imm, program_counter, data_pointer;
    logic [1:0] op_len, bank_select;
    logic res_we, bit_data, bit_we, stk_we, rerr, seen_br, seen_rw, seen_bw, seen_bd;
    int mismatches, total_checks, cycles;
    cdr_row_t rows [16] = '{
        '{OP_ADD, 8'hFF, 8'h01, 8'h00, 1'b1}, '{OP_SUBB, 8'h00, 8'h01, 8'hFF, 1'b1},
        '{OP_INC, 8'hFF, 8'h00, 8'h00, 1'b0}, '{OP_DEC, 8'h00, 8'h00, 8'hFF, 1'b0},
        '{OP_MUL, 8'h10, 8'h10, 8'h00, 1'b0}, '{OP_DIV, 8'h64, 8'h07, 8'h0E, 1'b0},
        '{OP_DA, 8'h0A, 8'h00, 8'h10, 1'b0}, '{OP_CMP, 8'h05, 8'h09, 8'h05, 1'b1},
        '{OP_ANL, 8'hF0, 8'h3C, 8'h30, 1'b0}, '{OP_ORL, 8'hF0, 8'h0F, 8'hFF, 1'b0},
        '{OP_XRL, 8'hFF, 8'h0F, 8'hF0, 1'b0}, '{OP_CPL, 8'h0F, 8'h00, 8'hF0, 1'b0},
        '{OP_RR, 8'h81, 8'h00, 8'hC0, 1'b0}, '{OP_RL, 8'h81, 8'h00, 8'h03, 1'b0},
        '{OP_SWAP, 8'hA5, 8'h00, 8'h5A, 1'b0}, '{OP_RRC, 8'h01, 8'h00, 8'h00, 1'b1}};

    cdr_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
        .op_src(op_src), .op_imm(op_imm), .op_len(op_len), .op_bit(op_bit),
        .op_bit_cy(op_bit_cy), .op_slow(op_slow), .op_done(op_done),
        .branch_taken(branch_taken), .res_data(res_data), .res_we(res_we),
        .bit_data(bit_data), .bit_we(bit_we), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
        .stk_we(stk_we), .stk_rdata(stk_rdata), .program_counter(program_counter),
        .data_pointer(data_pointer), .bank_select(bank_select));
    cdr_stack_ram u_ram (.sys_clk(sys_clk), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
        .stk_we(stk_we), .stk_rdata(stk_rdata));

    always #5 sys_clk = ~sys_clk;

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report;
        end
    end

    task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // an idle cycle after release keeps psel from being driven twice in one step
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task op(input cdr_op_t c, input logic [7:0] s, input logic [15:0] i, input logic [1:0] l,
        input logic b, input logic sl);
        op_code <= c;
        op_src <= s;
        op_imm <= i;
        op_len <= l;
        op_bit <= b;
        op_slow <= sl;
        op_valid <= 1'b1;
        do @(posedge sys_clk); while (op_ready !== 1'b1);
        op_valid <= 1'b0;
        do @(posedge sys_clk); while (op_done !== 1'b1);
        seen_br = branch_taken;
        seen_rw = res_we;
        seen_bw = bit_we;
        seen_bd = bit_data;
    endtask

    initial
    begin
        {sys_clk, rst_b, psel, penable, pwrite, op_valid, op_bit, op_bit_cy, op_slow} = '0;
        {paddr, pwdata, op_code, op_src, op_imm, op_len} = '0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        apb(1'b0, A_STK, 8'h00);
        check("stack reset", rdat, 8'h07);
        apb(1'b0, A_STAT, 8'h00);
        check("status reset", rdat, 8'h00);
        foreach (rows[k])
        begin
            apb(1'b1, A_STAT, 8'h00);
            apb(1'b1, A_ACC, rows[k].a);
            apb(1'b1, A_OPB, rows[k].s);
            op(rows[k].op, rows[k].s, 16'h0000, 2'd1, 1'b0, 1'b0);
            apb(1'b0, A_ACC, 8'h00);
            check("alu result", rdat, rows[k].ea);
            apb(1'b0, A_STAT, 8'h00);
            check("carry parity", rdat & 8'h81, {rows[k].ecy, 6'h00, ^rows[k].ea});
        end
        apb(1'b0, 8'hFC, 8'h00);
        check("unmapped", rerr, 1'b1);
        apb(1'b1, 8'h9C, 8'h55);
        check("counter write", rerr, 1'b1);
        apb(1'b1, A_ACC, 8'h00);
        apb(1'b1, A_STAT, 8'hFF);
        apb(1'b0, A_STAT, 8'h00);
        check("status write", rdat, 8'hFE);
        check("bank three", bank_select, 2'b11);
        apb(1'b1, A_STAT, 8'h08);
        check("bank one", bank_select, 2'b01);
        apb(1'b1, A_STK, 8'h30);
        apb(1'b0, A_STK, 8'h00);
        check("stack rw", rdat, 8'h30);
        apb(1'b1, A_STK, 8'h07);
        op(OP_PUSH, 8'h5A, 16'h0000, 2'd1, 1'b0, 1'b0);
        apb(1'b0, A_STK, 8'h00);
        check("push pointer", rdat, 8'h08);
        op(OP_POP, 8'h00, 16'h0000, 2'd1, 1'b0, 1'b0);
        check("pop strobe", seen_rw, 1'b1);
        check("pop data", res_data, 8'h5A);
        apb(1'b0, A_STK, 8'h00);
        check("pop pointer", rdat, 8'h07);
        op(OP_JMP, 8'h00, 16'h0100, 2'd3, 1'b0, 1'b0);
        op(OP_CALL, 8'h00, 16'h1234, 2'd3, 1'b0, 1'b0);
        check("call target", program_counter, 16'h1234);
        apb(1'b0, A_STK, 8'h00);
        check("call pointer", rdat, 8'h09);
        op(OP_RET, 8'h00, 16'h0000, 2'd1, 1'b0, 1'b1);
        check("return flag", seen_br, 1'b1);
        check("return pc", program_counter, 16'h0103);
        op(OP_DPLD, 8'h00, 16'h12FF, 2'd3, 1'b0, 1'b0);
        op(OP_DPINC, 8'h00, 16'h0000, 2'd1, 1'b0, 1'b1);
        check("pointer carry", data_pointer, 16'h1300);
        apb(1'b1, A_SEL, 8'h01);
        check("second pointer", data_pointer, 16'h0000);
        apb(1'b1, A_SEL, 8'h00);
        check("first pointer", data_pointer, 16'h1300);
        op(OP_SETB, 8'h00, 16'h0000, 2'd2, 1'b0, 1'b0);
        check("set bit", {seen_bw, seen_bd}, 2'b11);
        op(OP_JB, 8'h00, 16'h0200, 2'd3, 1'b1, 1'b0);
        check("bit branch", program_counter, 16'h0200);
        apb(1'b1, A_STAT, 8'h80);
        op(OP_ANLCN, 8'h00, 16'h0000, 2'd2, 1'b0, 1'b0);
        apb(1'b0, A_STAT, 8'h00);
        check("carry and not", rdat & 8'h80, 8'h80);
        final_report;
    end
endmodule

bind cdr_core cdr_core_properties u_props (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_src(op_src),
    .op_imm(op_imm), .op_slow(op_slow), .op_done(op_done), .branch_taken(branch_taken),
    .res_we(res_we), .stk_wdata(stk_wdata), .stk_we(stk_we),
    .program_counter(program_counter), .data_pointer(data_pointer));
